// ---- rtl/retry_card_device_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - retried master absent 2^15 clocks sets the matching expired flag.
// - retry status bit 7 enables host-side counter, resets one.
// - retry status bit 6 enables card-side counter, resets one.
// - bit 3 flags card retry expiry, write one clears, resets zero.
// - bit 1 flags host retry expiry, write one clears, resets zero.
// - retry status bits 5, 4, 2, 0 always read zero.
// - socket control bit 7 gates ring output to ring or multi terminals.
// - socket control bit 6 tristates video-port terminals, resets zero.
// - socket control bit 5 is plain storage with no effect.
// - socket control bit 2 routes card audio to pwm terminal.
// - socket control bit 1 passes speaker; terminal drives only then.
// - socket control bit 0 sets on card interrupt, write one clears.
// - mode bit 7 blocks socket power-down requests while in D3.
// - mode bit 6 forces reported 3-V capability, resets one.
// - mode bits 2:1 select interrupt signaling, reset value 11.
// - mode bit 5 diagnostic resets one; bit 4 reads zero.
module retry_card_device_ctrl
	import retry_card_pkg::*;
(
	// clock, reset, enable
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     clk_en,
	// configuration access
	input  retry_card_pkg::cfg_req_s      cfg_req,
	input  wire logic                     cfg_valid,
	output logic [7:0]                    cfg_rdata,
	output logic                          cfg_hit,
	// retry events
	input  retry_card_pkg::retry_evt_s    host_retry_evt,
	input  retry_card_pkg::retry_evt_s    card_retry_evt,
	// card pins
	input  wire logic                     card_func_irq_pin,
	input  wire logic                     card_speaker_pin,
	input  wire logic                     card_audio_pin,
	// system context
	input  wire logic                     ring_terminal_select,
	input  wire logic                     ring_event,
	input  wire logic                     in_d3,
	input  wire logic                     power_down_req,
	// outputs
	output logic                          ring_indicate_output,
	output logic                          multi_terminal_two,
	output logic                          multi_terminal_four,
	output logic                          video_port_tristate,
	output logic                          audio_pwm_output,
	output logic                          speaker_terminal,
	output logic                          speaker_terminal_oe,
	output logic                          socket_power_down,
	output logic                          low_volt_capable_force,
	output retry_card_pkg::irq_mode_e     irq_signaling_select
);

	logic [7:0] retry_q;
	logic [7:0] retry_d;
	logic [7:0] sock_q;
	logic [7:0] sock_d;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic       host_exp;
	logic       card_exp;
	logic [2:0] pins_s;
	logic       irq_s_q;
	logic       irq_rise;
	logic       wr_retry;
	logic       wr_sock;
	logic       wr_mode;

	// flag bits sit outside the write mask, so the keep-mask adds them back
	localparam logic [7:0] RETRY_FLAG_MASK =
		(8'h01 << CARD_EXP_BIT) | (8'h01 << HOST_EXP_BIT);
	localparam logic [7:0] RETRY_LIVE_MASK = RETRY_STATUS_WMASK | RETRY_FLAG_MASK;

	pin_sync u_sync (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_in  ({card_audio_pin, card_speaker_pin, card_func_irq_pin}),
		.pin_out (pins_s)
	);

	retry_timer u_host_timer (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.count_en (retry_q[HOST_EN_BIT]),
		.evt      (host_retry_evt),
		.expire   (host_exp)
	);

	retry_timer u_card_timer (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.count_en (retry_q[CARD_EN_BIT]),
		.evt      (card_retry_evt),
		.expire   (card_exp)
	);

	assign wr_retry = cfg_valid && cfg_req.wr && (cfg_req.addr == RETRY_STATUS_OFS);
	assign wr_sock  = cfg_valid && cfg_req.wr && (cfg_req.addr == SOCKET_CTRL_OFS);
	assign wr_mode  = cfg_valid && cfg_req.wr && (cfg_req.addr == IRQ_MODE_CTRL_OFS);
	// edge-sensitive card interrupt; flag set on the rising edge only
	assign irq_rise = pins_s[0] && !irq_s_q;

	always_comb
	begin
		retry_d = retry_q;
		sock_d  = sock_q;
		mode_d  = mode_q;
		if (wr_retry)
		begin
			retry_d = (retry_q & ~RETRY_STATUS_WMASK) | (cfg_req.wdata & RETRY_STATUS_WMASK);
			if (cfg_req.wdata[CARD_EXP_BIT])
				retry_d[CARD_EXP_BIT] = 1'b0;
			if (cfg_req.wdata[HOST_EXP_BIT])
				retry_d[HOST_EXP_BIT] = 1'b0;
		end
		// expiry sets flag, wins over clear
		if (card_exp)
			retry_d[CARD_EXP_BIT] = 1'b1;
		if (host_exp)
			retry_d[HOST_EXP_BIT] = 1'b1;
		retry_d = retry_d & RETRY_LIVE_MASK;
		if (wr_sock)
		begin
			sock_d = (sock_q & ~SOCKET_CTRL_WMASK) | (cfg_req.wdata & SOCKET_CTRL_WMASK);
			if (cfg_req.wdata[FUNC_IRQ_BIT])
				sock_d[FUNC_IRQ_BIT] = 1'b0;
		end
		if (irq_rise)
			sock_d[FUNC_IRQ_BIT] = 1'b1;
		if (wr_mode)
			mode_d = cfg_req.wdata & IRQ_MODE_CTRL_WMASK;
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			retry_q <= RETRY_STATUS_RST;
			sock_q  <= SOCKET_CTRL_RST;
			mode_q  <= IRQ_MODE_CTRL_RST;
			irq_s_q <= 1'b0;
		end
		else if (clk_en)
		begin
			retry_q <= retry_d;
			sock_q  <= sock_d;
			mode_q  <= mode_d;
			irq_s_q <= pins_s[0];
		end
	end

	always_comb
	begin
		cfg_hit = cfg_valid && ((cfg_req.addr == RETRY_STATUS_OFS) ||
			(cfg_req.addr == SOCKET_CTRL_OFS) || (cfg_req.addr == IRQ_MODE_CTRL_OFS));
	end

	// read data registered; unmapped reads return zero
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_rdata <= 8'h00;
		else if (clk_en)
		begin
			case (cfg_req.addr)
				RETRY_STATUS_OFS:  cfg_rdata <= retry_q;
				SOCKET_CTRL_OFS:   cfg_rdata <= sock_q;
				IRQ_MODE_CTRL_OFS: cfg_rdata <= mode_q;
				default:           cfg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ring_indicate_output   <= 1'b0;
			multi_terminal_two     <= 1'b0;
			multi_terminal_four    <= 1'b0;
			video_port_tristate    <= 1'b0;
			audio_pwm_output       <= 1'b0;
			speaker_terminal       <= 1'b0;
			socket_power_down      <= 1'b0;
		end
		else if (clk_en)
		begin
			ring_indicate_output <= sock_q[RING_EN_BIT] && !ring_terminal_select && ring_event;
			multi_terminal_two   <= sock_q[RING_EN_BIT] && ring_event;
			multi_terminal_four  <= sock_q[RING_EN_BIT] && ring_event;
			video_port_tristate  <= sock_q[VIDEO_TRI_BIT];
			audio_pwm_output     <= sock_q[AUDIO_ROUTE_BIT] && pins_s[2];
			speaker_terminal     <= sock_q[SPKR_EN_BIT] && pins_s[1];
			socket_power_down    <= power_down_req && !(mode_q[PWR_HOLD_BIT] && in_d3);
		end
	end

	assign speaker_terminal_oe    = sock_q[SPKR_EN_BIT];
	assign low_volt_capable_force = mode_q[LV_FORCE_BIT];
	assign irq_signaling_select   = irq_mode_e'(mode_q[IRQ_MODE_LSB +: 2]);

	a_host_exp_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && host_exp) |=> retry_q[HOST_EXP_BIT])
		else $error("host expiry flag not set");
	a_card_exp_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && card_exp) |=> retry_q[CARD_EXP_BIT])
		else $error("card expiry flag not set");
	a_host_exp_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && wr_retry && cfg_req.wdata[HOST_EXP_BIT] && !host_exp)
		|=> !retry_q[HOST_EXP_BIT])
		else $error("host expiry flag not cleared");
	a_retry_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(retry_q & ~RETRY_LIVE_MASK) == 8'h00)
		else $error("retry reserved bit set");
	a_ring_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && !sock_q[RING_EN_BIT]) |=> !ring_indicate_output && !multi_terminal_two)
		else $error("ring routed while disabled");
	a_spkr_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && !sock_q[SPKR_EN_BIT]) |=> !speaker_terminal)
		else $error("speaker drove data while disabled");
	a_irq_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && irq_rise) |=> sock_q[FUNC_IRQ_BIT])
		else $error("card interrupt flag lost");
	a_pwr_lock: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && mode_q[PWR_HOLD_BIT] && in_d3) |=> !socket_power_down)
		else $error("power-down passed while locked");
	a_mode_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q & ~IRQ_MODE_CTRL_WMASK) == 8'h00)
		else $error("mode reserved bit set");

	// expiry pulses last one enabled cycle; a returned master stops its timer
	a_host_pause: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!retry_q[HOST_EN_BIT] |-> !host_exp)
		else $error("host timer expired while disabled");
	a_card_pause: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!retry_q[CARD_EN_BIT] |-> !card_exp)
		else $error("card timer expired while disabled");
	a_card_exp_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && wr_retry && cfg_req.wdata[CARD_EXP_BIT] && !card_exp)
		|=> !retry_q[CARD_EXP_BIT])
		else $error("card expiry flag not cleared");
	a_host_exp_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && host_exp) |=> !host_exp)
		else $error("host expiry held past one cycle");
	a_card_exp_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && card_exp) |=> !card_exp)
		else $error("card expiry held past one cycle");
	a_card_return: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && card_retry_evt.master_return && !card_retry_evt.retry_start) |=> !card_exp)
		else $error("card timer expired after master return");
	a_ring_mux: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && ring_terminal_select) |=> !ring_indicate_output)
		else $error("ring output routed with mux selected away");
	a_video_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
		clk_en |=> (video_port_tristate == $past(sock_q[VIDEO_TRI_BIT])))
		else $error("video tristate does not follow control bit");
	a_sock_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && wr_sock) |=> ((sock_q & SOCKET_CTRL_WMASK) ==
			($past(cfg_req.wdata) & SOCKET_CTRL_WMASK)))
		else $error("socket control write not stored");
	a_audio_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && !sock_q[AUDIO_ROUTE_BIT]) |=> !audio_pwm_output)
		else $error("card audio routed while disabled");
	a_irq_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && wr_sock && cfg_req.wdata[FUNC_IRQ_BIT] && !irq_rise)
		|=> !sock_q[FUNC_IRQ_BIT])
		else $error("card interrupt flag not cleared");
	a_pwr_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && power_down_req && !in_d3) |=> socket_power_down)
		else $error("power-down request dropped outside low power");
	a_mode_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && wr_mode) |=> (mode_q == ($past(cfg_req.wdata) & IRQ_MODE_CTRL_WMASK)))
		else $error("mode control write not stored");

	c_host_exp: cover property (@(posedge ref_clk) disable iff (sys_rst) host_exp);
	c_irq_clear: cover property (@(posedge ref_clk) disable iff (sys_rst)
		sock_q[FUNC_IRQ_BIT] ##1 !sock_q[FUNC_IRQ_BIT]);
	c_lock_block: cover property (@(posedge ref_clk) disable iff (sys_rst)
		power_down_req && in_d3 && mode_q[PWR_HOLD_BIT]);
	c_card_return: cover property (@(posedge ref_clk) disable iff (sys_rst)
		card_retry_evt.master_return);
	c_frozen_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
		!clk_en && wr_sock);

endmodule : retry_card_device_ctrl

// ---- rtl/retry_card_pkg.sv ----
package retry_card_pkg;

	localparam logic [7:0] RETRY_STATUS_OFS   = 8'h90;
	localparam logic [7:0] SOCKET_CTRL_OFS    = 8'h91;
	localparam logic [7:0] IRQ_MODE_CTRL_OFS  = 8'h92;

	localparam logic [7:0] RETRY_STATUS_RST   = 8'hC0;
	localparam logic [7:0] SOCKET_CTRL_RST    = 8'h00;
	localparam logic [7:0] IRQ_MODE_CTRL_RST  = 8'h66;

	// writable masks per register
	localparam logic [7:0] RETRY_STATUS_WMASK = 8'hC0;
	localparam logic [7:0] SOCKET_CTRL_WMASK  = 8'hE6;
	localparam logic [7:0] IRQ_MODE_CTRL_WMASK = 8'hEF;

	localparam int HOST_EN_BIT      = 7;
	localparam int CARD_EN_BIT      = 6;
	localparam int CARD_EXP_BIT     = 3;
	localparam int HOST_EXP_BIT     = 1;
	localparam int RING_EN_BIT      = 7;
	localparam int VIDEO_TRI_BIT    = 6;
	localparam int AUDIO_ROUTE_BIT  = 2;
	localparam int SPKR_EN_BIT      = 1;
	localparam int FUNC_IRQ_BIT     = 0;
	localparam int PWR_HOLD_BIT     = 7;
	localparam int LV_FORCE_BIT     = 6;
	localparam int IRQ_MODE_LSB     = 1;

	// retry timeout: 2^15 clock cycles
	localparam int RETRY_TIMEOUT_CYCLES = 32768;
	localparam int RETRY_CNT_W          = 16;

	typedef enum logic [1:0] {
		IRQ_PAR_PCI_ONLY,
		IRQ_PAR_IRQ_PAR_PCI,
		IRQ_SER_IRQ_PAR_PCI,
		IRQ_SER_ALL
	} irq_mode_e;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_req_s;

	typedef struct packed {
		logic retry_start;
		logic master_return;
	} retry_evt_s;

endpackage : retry_card_pkg

// ---- rtl/retry_timer.sv ----
`timescale 1ns/1ps
module retry_timer
	import retry_card_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// control
	input  wire logic       count_en,
	input  retry_card_pkg::retry_evt_s evt,
	// result
	output logic            expire
);

	localparam logic [RETRY_CNT_W-1:0] LAST =
		RETRY_CNT_W'(RETRY_TIMEOUT_CYCLES - 1);

	logic [RETRY_CNT_W-1:0] cnt_q;
	logic [RETRY_CNT_W-1:0] cnt_d;
	logic                   busy_q;
	logic                   busy_d;

	always_comb
	begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		expire = 1'b0;
		if (evt.retry_start)
		begin
			busy_d = 1'b1;
			cnt_d  = '0;
		end
		else if (evt.master_return)
		begin
			busy_d = 1'b0;
			cnt_d  = '0;
		end
		else if (busy_q && count_en)
		begin
			if (cnt_q == LAST)
			begin
				expire = 1'b1;
				busy_d = 1'b0;
				cnt_d  = '0;
			end
			else
			begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end
		else if (clk_en)
		begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
		end
	end

	a_pause_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clk_en && !count_en && !evt.retry_start && !evt.master_return) |=> $stable(cnt_q))
		else $error("retry counter moved while disabled");

endmodule : retry_timer

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// pins
	input  wire logic [2:0] pin_in,
	output logic      [2:0] pin_out
);

	logic [2:0] meta_q;
	logic [2:0] sync_q;

	// two flops per pin; second alone feeds logic
	for (genvar i = 0; i < 3; i++)
	begin : g_sync
		always_ff @(posedge ref_clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				meta_q[i] <= 1'b0;
				sync_q[i] <= 1'b0;
			end
			else if (clk_en)
			begin
				meta_q[i] <= pin_in[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	assign pin_out = sync_q;

endmodule : pin_sync

// ---- verification/retry_master_model.sv ----
`timescale 1ns/1ps
module retry_master_model
	import retry_card_pkg::*;
(
	// control
	input  wire logic       ref_clk,
	input  wire logic       go,
	input  wire logic [7:0] ret_after,
	// events
	output retry_card_pkg::retry_evt_s evt
);
	import retry_card_pkg::*;
	int cnt = 0;
	always @(posedge ref_clk)
	begin
		evt.retry_start <= go;
		evt.master_return <= (cnt == 1);
		if (go)
			cnt <= ret_after;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule : retry_master_model

// ---- verification/retry_card_device_ctrl_bench.sv ----
`timescale 1ns/1ps
module retry_card_device_ctrl_bench;
	import retry_card_pkg::*;
	logic ref_clk, sys_rst, clk_en, cfg_valid, cfg_hit;
	logic card_func_irq_pin, card_speaker_pin, card_audio_pin;
	logic ring_terminal_select, ring_event, in_d3, power_down_req;
	logic ring_indicate_output, multi_terminal_two, multi_terminal_four;
	logic video_port_tristate, audio_pwm_output, speaker_terminal;
	logic speaker_terminal_oe, socket_power_down, low_volt_capable_force;
	logic [7:0] cfg_rdata, cret, w, r91, r92;
	logic hgo, cgo;
	cfg_req_s   cfg_req;
	retry_evt_s host_retry_evt, card_retry_evt;
	irq_mode_e  irq_signaling_select;
	int err_count, n_tests, i;
	integer seed = 34674;

	retry_card_device_ctrl retry_card_device_ctrl_inst (.*);
	retry_master_model host_model (.ref_clk, .go(hgo), .ret_after(8'h00),
		.evt(host_retry_evt));
	retry_master_model card_model (.ref_clk, .go(cgo), .ret_after(cret),
		.evt(card_retry_evt));

	initial
	begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick

	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(logic [7:0] a, logic [7:0] d);
		tick();
		cfg_req = '{wr: 1'b1, addr: a, wdata: d};
		cfg_valid = 1;
		tick();
		chk("hit", cfg_hit, (a == RETRY_STATUS_OFS) || (a == SOCKET_CTRL_OFS) ||
			(a == IRQ_MODE_CTRL_OFS));
		cfg_valid = 0;
		cfg_req.wr = 0;
	endtask : wr

	task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
		tick();
		cfg_req = '{wr: 1'b0, addr: a, wdata: 8'h00};
		tick();
		chk(nm, cfg_rdata, e);
	endtask : rd

	task automatic pulse_retry();
		tick();
		hgo = 1;
		cgo = 1;
		tick();
		hgo = 0;
		cgo = 0;
	endtask : pulse_retry

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	// long retry waits dominate the run
	initial
	begin
		repeat (90000) @(posedge ref_clk);
		err_count++;
		wrap_up();
	end

	initial
	begin
		err_count = 0;
		n_tests = 0;
		sys_rst = 1;
		clk_en = 1;
		cfg_valid = 0;
		cfg_req = '0;
		{card_func_irq_pin, card_speaker_pin, card_audio_pin} = 3'h0;
		{ring_terminal_select, ring_event, in_d3, power_down_req} = 4'h0;
		{hgo, cgo} = 2'h0;
		cret = 8'h0A;
		repeat (3) @(posedge ref_clk);
		#1;
		sys_rst = 0;
		rd(8'h90, 8'hC0, "retry_rst");
		rd(8'h91, 8'h00, "socket_rst");
		rd(8'h92, 8'h66, "mode_rst");
		wr(8'h93, 8'hFF);
		rd(8'h93, 8'h00, "unmapped");
		chk("lv_rst", low_volt_capable_force, 8'h01);
		chk("mode_rst", irq_signaling_select, 8'h03);
		$display("test reset done");
		for (i = 0; i < 16; i++)
		begin
			w = 8'($random(seed));
			wr(8'h90, w);
			rd(8'h90, w & 8'hC0, "retry_rw");
			w = 8'($random(seed));
			r91 = w & 8'hE6;
			wr(8'h91, w);
			r92 = 8'($random(seed)) & 8'hE6;
			wr(8'h92, r92);
			{card_speaker_pin, card_audio_pin, ring_terminal_select} = 3'($random(seed));
			{ring_event, in_d3, power_down_req} = 3'($random(seed));
			if (i == 0)
				{r92[7], in_d3, power_down_req} = 3'h7;
			wr(8'h92, r92);
			repeat (5) tick();
			rd(8'h91, r91, "socket_rw");
			rd(8'h92, r92, "mode_rw");
			chk("video", video_port_tristate, r91[6]);
			chk("spk_oe", speaker_terminal_oe, r91[1]);
			chk("spk", speaker_terminal, card_speaker_pin & r91[1]);
			chk("audio", audio_pwm_output, card_audio_pin & r91[2]);
			chk("ring", ring_indicate_output,
				r91[7] & ~ring_terminal_select & ring_event);
			chk("mf2", multi_terminal_two, r91[7] & ring_event);
			chk("mf4", multi_terminal_four, r91[7] & ring_event);
			chk("pwr", socket_power_down, power_down_req & ~(r92[7] & in_d3));
			chk("lv", low_volt_capable_force, r92[6]);
			chk("mode", irq_signaling_select, r92[2:1]);
		end
		$display("test random registers done");
		clk_en = 0;
		wr(8'h91, r91 ^ 8'hE6);
		clk_en = 1;
		rd(8'h91, r91, "frozen");
		$display("test clock enable done");
		wr(8'h91, 8'h00);
		card_func_irq_pin = 1;
		repeat (6) tick();
		rd(8'h91, 8'h01, "irq_set");
		wr(8'h91, 8'hFF);
		rd(8'h91, 8'hE6, "irq_clear");
		$display("test card interrupt done");
		wr(8'h90, 8'hC0);
		pulse_retry();
		repeat (32700) @(posedge ref_clk);
		rd(8'h90, 8'hC0, "early");
		repeat (100) @(posedge ref_clk);
		rd(8'h90, 8'hC2, "host_exp");
		wr(8'h90, 8'hC2);
		rd(8'h90, 8'hC0, "host_clr");
		$display("test host expiry done");
		wr(8'h90, 8'h40);
		cret = 8'h00;
		pulse_retry();
		repeat (32800) @(posedge ref_clk);
		rd(8'h90, 8'h48, "card_exp");
		wr(8'h90, 8'h48);
		rd(8'h90, 8'h40, "card_clr");
		$display("test card expiry done");
		wrap_up();
	end
endmodule : retry_card_device_ctrl_bench
